// >>> rac_alarm_cal.sv
// alarm compare, repeat and calibration logic of the calendar clock, behind an APB slave
// How it works
// - weekday digit sits in bits 10..8 of weekday/hours, values 0..6; the register also holds 7
// - hour tens in bits 5..4, hour units in bits 3..0
// - minute tens in bits 14..12, minute units in bits 11..8
// - second tens in bits 6..4, units in 3..0; unused bits read zero
// - weekday/hours writes are dropped unless clock write enable is one
// - each minute with the timer on, the signed calibration byte times four goes to the timer
// - negative calibration removes pulses, positive adds them
// - alarm enable bit 15 gates every alarm
// - mask field bits 13..10 selects the alarm interval
// - mask codes 0..9 mean half second up to yearly
// - alarm fires when every digit chosen by the mask matches
// - repeat counter bits 7..0 drops by one per alarm
// - repeat zero and chime clear gives exactly one alarm
// - final alarm at zero without chime clears the enable bit
// - with chime set the counter wraps from 00 to FF
// - loading FF allows 255 more alarms after the first
// - every alarm raises the interrupt request
// - alarm pulse output toggles on each alarm
// - window pointer picks the value pair, counts down on high half access
//
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`include "rac_defs.svh"

module rac_alarm_cal
  import rac_pkg::*;
#(
  parameter int CAL_W = 8
)
(
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        halfTick,
  input  wire logic        secondEdge,
  input  wire logic        minuteTick,
  input  wire logic        clockSync,
  input  wire logic [6:0]  nowSec,
  input  wire logic [6:0]  nowMin,
  input  wire logic [5:0]  nowHour,
  input  wire logic [2:0]  nowWday,
  input  wire logic [5:0]  nowDay,
  input  wire logic [4:0]  nowMonth,
  input  wire logic [5:0]  alarmDay,
  input  wire logic [4:0]  alarmMonth,
  output logic             alarmIrq,
  output logic             alarmPulse,
  output logic             calApply,
  output logic [CAL_W+1:0] calPulses,
  output logic             timerOn
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic             preadyReg, preadyNext;
  logic             slvErrReg, slvErrNext;
  logic [31:0]      rdataReg, rdataNext;
  logic             enReg, enNext;
  logic             chimeReg, chimeNext;
  logic [3:0]       maskReg, maskNext;
  logic [1:0]       ptrReg, ptrNext;
  logic [7:0]       rptReg, rptNext;
  logic             onReg, onNext;
  logic             wrenReg, wrenNext;
  logic [CAL_W-1:0] calReg, calNext;
  logic [2:0]       wdayReg, wdayNext;
  logic [5:0]       hourReg, hourNext;
  logic [6:0]       minReg, minNext;
  logic [6:0]       secReg, secNext;
  logic             irqReg, irqNext;
  logic             pulseReg, pulseNext;
  logic             applyReg, applyNext;
  logic [CAL_W+1:0] pulsesReg, pulsesNext;
  logic             fire, wrFire, rdFire, mapped, match, alarmEvt;
  logic [15:0]      cfgWord, calWord, wdhrWord, msWord;
  logic [7:0]       winLo, winHi;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  // the access is taken on the edge where the master sees pready
  assign fire   = ce & psel & penable & preadyReg;
  assign wrFire = fire & pwrite;
  assign rdFire = fire & ~pwrite;
  assign mapped = (paddr == `RAC_OFS_CFG) | (paddr == `RAC_OFS_CAL) |
                  (paddr == `RAC_OFS_WINLO) | (paddr == `RAC_OFS_WINHI) |
                  (paddr == `RAC_OFS_WDHR) | (paddr == `RAC_OFS_MINSEC);

  // read views of the registers, unused bits zero
  assign cfgWord  = {enReg, chimeReg, maskReg, ptrReg, rptReg};
  assign calWord  = {onReg, 1'b0, wrenReg, clockSync, 4'h0, calReg};
  assign wdhrWord = {5'h00, wdayReg, 2'h0, hourReg};
  assign msWord   = {1'b0, minReg, 1'b0, secReg};

  // window halves follow the pointer; pairs 10 and 11 are not held here
  always_comb
  begin
    winLo = 8'h00;
    winHi = 8'h00;
    case (ptrReg)
      `RAC_PTR_MINSEC:
      begin
        winLo = msWord[7:0];
        winHi = msWord[15:8];
      end
      `RAC_PTR_WDHR:
      begin
        winLo = wdhrWord[7:0];
        winHi = wdhrWord[15:8];
      end
      default:
      begin
        winLo = 8'h00;
        winHi = 8'h00;
      end
    endcase
  end

  // ----------------------------------------
  // alarm match
  // ----------------------------------------
  // wider intervals compare more digits; reserved codes never match
  always_comb
  begin
    match = 1'b0;
    case (rac_mask_t'(maskReg))
      RAC_HALFSEC: match = 1'b1;
      RAC_SEC:     match = secondEdge;
      RAC_TENSEC:  match = secondEdge & (nowSec[3:0] == secReg[3:0]);
      RAC_MINUTE:  match = secondEdge & (nowSec == secReg);
      RAC_TENMIN:  match = secondEdge & (nowSec == secReg) &
                           (nowMin[3:0] == minReg[3:0]);
      RAC_HOUR:    match = secondEdge & (nowSec == secReg) & (nowMin == minReg);
      RAC_DAY:     match = secondEdge & (nowSec == secReg) & (nowMin == minReg) &
                           (nowHour == hourReg);
      RAC_WEEK:    match = secondEdge & (nowSec == secReg) & (nowMin == minReg) &
                           (nowHour == hourReg) & (nowWday == wdayReg);
      RAC_MONTH:   match = secondEdge & (nowSec == secReg) & (nowMin == minReg) &
                           (nowHour == hourReg) & (nowDay == alarmDay);
      RAC_YEAR:    match = secondEdge & (nowSec == secReg) & (nowMin == minReg) &
                           (nowHour == hourReg) & (nowDay == alarmDay) &
                           (nowMonth == alarmMonth);
      default:     match = 1'b0;
    endcase
  end

  // one event per half-second tick, so a held match fires once
  assign alarmEvt = ce & halfTick & enReg & match;

  // ----------------------------------------
  // bus answer: one wait cycle, then pready for one cycle
  // ----------------------------------------
  always_comb
  begin
    preadyNext = psel & penable & ~preadyReg;
    slvErrNext = 1'b0;
    rdataNext  = rdataReg;
    if (psel & penable & ~preadyReg)
    begin
      slvErrNext = ~mapped;
      rdataNext  = `RAC_ZERO32;
      case (paddr)
        `RAC_OFS_CFG:    rdataNext = {16'h0000, cfgWord};
        `RAC_OFS_CAL:    rdataNext = {16'h0000, calWord};
        `RAC_OFS_WINLO:  rdataNext = {24'h000000, winLo};
        `RAC_OFS_WINHI:  rdataNext = {24'h000000, winHi};
        `RAC_OFS_WDHR:   rdataNext = {16'h0000, wdhrWord};
        `RAC_OFS_MINSEC: rdataNext = {16'h0000, msWord};
        default:         rdataNext = `RAC_ZERO32;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      preadyReg <= 1'b0;
      slvErrReg <= 1'b0;
      rdataReg  <= `RAC_ZERO32;
    end
    else if (ce)
    begin
      preadyReg <= preadyNext;
      slvErrReg <= slvErrNext;
      rdataReg  <= rdataNext;
    end
  end

  // ----------------------------------------
  // configuration, calibration and alarm values
  // ----------------------------------------
  // the alarm's own update is applied after the software write, so the
  // hardware result wins when both land on one edge
  always_comb
  begin
    enNext    = enReg;
    chimeNext = chimeReg;
    maskNext  = maskReg;
    ptrNext   = ptrReg;
    rptNext   = rptReg;
    onNext    = onReg;
    wrenNext  = wrenReg;
    calNext   = calReg;
    wdayNext  = wdayReg;
    hourNext  = hourReg;
    minNext   = minReg;
    secNext   = secReg;
    if (wrFire && paddr == `RAC_OFS_CFG)
    begin
      enNext    = pwdata[`RAC_CFG_EN];
      chimeNext = pwdata[`RAC_CFG_CHIME];
      maskNext  = pwdata[`RAC_CFG_MASKH:`RAC_CFG_MASKL];
      ptrNext   = pwdata[`RAC_CFG_PTRH:`RAC_CFG_PTRL];
      rptNext   = pwdata[`RAC_CFG_RPTH:0];
    end
    if (wrFire && paddr == `RAC_OFS_CAL)
    begin
      onNext   = pwdata[`RAC_CAL_ON];
      wrenNext = pwdata[`RAC_CAL_WREN];
      calNext  = pwdata[`RAC_CAL_H:0];
    end
    // weekday/hours is locked while write enable is low
    if (wrFire && paddr == `RAC_OFS_WDHR && wrenReg)
    begin
      wdayNext = pwdata[`RAC_WEEKDAY_DIGIT_H:`RAC_WEEKDAY_DIGIT_L];
      hourNext = pwdata[`RAC_HOUR_H:0];
    end
    if (wrFire && paddr == `RAC_OFS_MINSEC)
    begin
      minNext = pwdata[`RAC_MIN_H:`RAC_MIN_L];
      secNext = pwdata[`RAC_SEC_H:0];
    end
    // window writes go to the pair the pointer selects
    if (wrFire && paddr == `RAC_OFS_WINLO)
    begin
      if (ptrReg == `RAC_PTR_MINSEC)
        secNext = pwdata[`RAC_SEC_H:0];
      else if (ptrReg == `RAC_PTR_WDHR && wrenReg)
        hourNext = pwdata[`RAC_HOUR_H:0];
    end
    if (wrFire && paddr == `RAC_OFS_WINHI)
    begin
      if (ptrReg == `RAC_PTR_MINSEC)
        minNext = pwdata[`RAC_MIN_H-`RAC_MIN_L:0];
      else if (ptrReg == `RAC_PTR_WDHR && wrenReg)
        wdayNext = pwdata[`RAC_WEEKDAY_DIGIT_H-`RAC_WEEKDAY_DIGIT_L:0];
    end
    // each high-half access steps the pointer down, stopping at zero
    if (fire && paddr == `RAC_OFS_WINHI && ptrReg != 2'h0)
      ptrNext = ptrReg - 2'h1;
    // repeat counter and self-disable on each alarm
    if (alarmEvt)
    begin
      if (rptReg != `RAC_RPT_ZERO)
        rptNext = rptReg - 8'h01;
      else if (chimeReg)
        rptNext = `RAC_RPT_WRAP;
      else
        enNext = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      enReg    <= 1'b0;
      chimeReg <= 1'b0;
      maskReg  <= 4'h0;
      ptrReg   <= 2'h0;
      rptReg   <= `RAC_RPT_ZERO;
      onReg    <= 1'b0;
      wrenReg  <= 1'b0;
      calReg   <= '0;
      wdayReg  <= 3'h0;
      hourReg  <= 6'h00;
      minReg   <= 7'h00;
      secReg   <= 7'h00;
    end
    else if (ce)
    begin
      enReg    <= enNext;
      chimeReg <= chimeNext;
      maskReg  <= maskNext;
      ptrReg   <= ptrNext;
      rptReg   <= rptNext;
      onReg    <= onNext;
      wrenReg  <= wrenNext;
      calReg   <= calNext;
      wdayReg  <= wdayNext;
      hourReg  <= hourNext;
      minReg   <= minNext;
      secReg   <= secNext;
    end
  end

  // ----------------------------------------
  // event outputs and calibration pulse
  // ----------------------------------------
  // correction is sign-extended and scaled by four; timer adds or drops it
  always_comb
  begin
    irqNext    = alarmEvt;
    pulseNext  = pulseReg ^ alarmEvt;
    applyNext  = minuteTick & onReg;
    pulsesNext = pulsesReg;
    if (minuteTick && onReg)
      pulsesNext = {calReg[CAL_W-1], calReg[CAL_W-1], calReg} <<< 2;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      irqReg    <= 1'b0;
      pulseReg  <= 1'b0;
      applyReg  <= 1'b0;
      pulsesReg <= '0;
    end
    else if (ce)
    begin
      irqReg    <= irqNext;
      pulseReg  <= pulseNext;
      applyReg  <= applyNext;
      pulsesReg <= pulsesNext;
    end
  end

  assign prdata    = rdataReg;
  assign pready    = preadyReg;
  assign pslverr   = slvErrReg;
  assign alarmIrq  = irqReg;
  assign alarmPulse = pulseReg;
  assign calApply  = applyReg;
  assign calPulses = pulsesReg;
  assign timerOn   = onReg;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  sequence accessWait;
    psel && penable && !preadyReg && ce;
  endsequence
  sequence alarmAtZero;
    alarmEvt && rptReg == `RAC_RPT_ZERO;
  endsequence

  apbAnswer_a: assert property (accessWait |=> preadyReg)
    else $error("bus access not answered after one wait cycle");
  wdhrLock_a: assert property (wrFire && paddr == `RAC_OFS_WDHR && !wrenReg |=> $stable(wdayReg) && $stable(hourReg))
    else $error("weekday/hours changed while write enable low");
  repeatDown_a: assert property (alarmEvt && rptReg != `RAC_RPT_ZERO |=> rptReg == $past(rptReg) - 8'h01)
    else $error("repeat counter did not drop by one");
  oneShotOff_a: assert property (alarmAtZero and !chimeReg |=> !enReg)
    else $error("alarm not disabled after final alarm");
  chimeWrap_a: assert property (alarmAtZero and chimeReg |=> rptReg == `RAC_RPT_WRAP && enReg)
    else $error("chime did not wrap repeat counter");
  irqEvent_a: assert property (alarmEvt |=> alarmIrq ##1 (alarmIrq == $past(alarmEvt) || !$past(ce)))
    else $error("interrupt not raised for alarm");
  pulseToggle_a: assert property (alarmEvt |=> alarmPulse != $past(alarmPulse))
    else $error("alarm pulse did not toggle");
  noAlarmOff_a: assert property (ce && !enReg |=> !alarmIrq)
    else $error("alarm issued while disabled");
  calScale_a: assert property (ce && minuteTick && onReg |=> calApply && calPulses == 10'(signed'($past(calReg)) * 4))
    else $error("calibration correction wrong");
  ptrDown_a: assert property ((rdFire || wrFire) && paddr == `RAC_OFS_WINHI && ptrReg != 2'h0 |=> ptrReg == $past(ptrReg) - 2'h1)
    else $error("window pointer did not count down");

endmodule : rac_alarm_cal

// >>> rac_defs.svh
// register offsets, field positions and reset values of the alarm and calibration block
`ifndef RAC_DEFS_SVH
`define RAC_DEFS_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define RAC_OFS_CFG    8'h00
`define RAC_OFS_CAL    8'h04
`define RAC_OFS_WINLO  8'h08
`define RAC_OFS_WINHI  8'h0C
`define RAC_OFS_WDHR   8'h10
`define RAC_OFS_MINSEC 8'h14
// ----------------------------------------
// alarm_config_repeat fields
// ----------------------------------------
`define RAC_CFG_EN     15
`define RAC_CFG_CHIME  14
`define RAC_CFG_MASKH  13
`define RAC_CFG_MASKL  10
`define RAC_CFG_PTRH   9
`define RAC_CFG_PTRL   8
`define RAC_CFG_RPTH   7
// ----------------------------------------
// clock_config_calibration fields
// ----------------------------------------
`define RAC_CAL_ON     15
`define RAC_CAL_WREN   13
`define RAC_CAL_SYNC   12
`define RAC_CAL_H      7
// ----------------------------------------
// value field positions
// ----------------------------------------
`define RAC_WEEKDAY_DIGIT_H     10
`define RAC_WEEKDAY_DIGIT_L     8
`define RAC_HOUR_H     5
`define RAC_MIN_H      14
`define RAC_MIN_L      8
`define RAC_SEC_H      6
// ----------------------------------------
// constants
// ----------------------------------------
`define RAC_PTR_WDHR   2'h1
`define RAC_PTR_MINSEC 2'h0
`define RAC_RPT_ZERO   8'h00
`define RAC_RPT_WRAP   8'hFF
`define RAC_ZERO32     32'h0000_0000
`endif

// >>> rac_pkg.sv
// types shared by the alarm and calibration block
package rac_pkg;
  // alarm interval codes in mask order
  typedef enum logic [3:0] {
    RAC_HALFSEC,
    RAC_SEC,
    RAC_TENSEC,
    RAC_MINUTE,
    RAC_TENMIN,
    RAC_HOUR,
    RAC_DAY,
    RAC_WEEK,
    RAC_MONTH,
    RAC_YEAR
  } rac_mask_t;
endpackage : rac_pkg

// >>> test_rtc_alarm_and_calibration.sv
// self-checking bench for the alarm and calibration block
`timescale 1ns/1ps
`include "rac_defs.svh"
`define CHK(got, exp) \
  begin \
    compares++; \
    if ((got) !== (exp)) \
    begin \
      miscompares++; \
      $display("MISMATCH at %0t got %h expected %h", $time, got, exp); \
    end \
  end

module test_rtc_alarm_and_calibration
  import rac_pkg::*;
;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] r; logic e;} rac_tb_row_t;
  logic        clock, rstn, ce, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic        halfTick, secondEdge, minuteTick, clockSync;
  logic [6:0]  nowSec, nowMin;
  logic [5:0]  nowHour, nowDay;
  logic [2:0]  nowWday;
  logic [4:0]  nowMonth;
  logic        alarmIrq, alarmPulse, calApply, timerOn, errv, expPulse;
  logic [9:0]  calPulses;
  int          miscompares, compares;
  rac_tb_row_t rows [6];
  logic [7:0]  calVal [4] = '{8'hFD, 8'h05, 8'h80, 8'h7F};
  logic [9:0]  calExp [4] = '{10'h3F4, 10'h014, 10'h200, 10'h1FC};

  rac_alarm_cal #(.CAL_W(8)) uut (
    .clock(clock), .rstn(rstn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .halfTick(halfTick), .secondEdge(secondEdge), .minuteTick(minuteTick), .clockSync(clockSync),
    .nowSec(nowSec), .nowMin(nowMin), .nowHour(nowHour), .nowWday(nowWday), .nowDay(nowDay),
    .nowMonth(nowMonth), .alarmDay(6'h15), .alarmMonth(5'h11), .alarmIrq(alarmIrq),
    .alarmPulse(alarmPulse), .calApply(calApply), .calPulses(calPulses), .timerOn(timerOn)
  );

  // ----------------------------------------
  // clock and watchdog
  // ----------------------------------------
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // a hang anywhere still reaches the verdict
  initial
  begin
    repeat (60000) @(posedge clock);
    miscompares++;
    end_of_test();
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic end_of_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  // one APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      miscompares++;
      end_of_test();
    end
    rdv = prdata;
    errv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(rdv, exp)
  endtask : rd

  // one half-second tick; bad spoils the widest digit the mask code selects
  task automatic tick(input int code, input bit bad, input logic expIrq);
    @(posedge clock);
    halfTick   <= 1'b1;
    secondEdge <= !(bad && code == 1);
    nowSec     <= (bad && code == 2) ? 7'h28 : (bad && code == 3) ? 7'h37 : 7'h27;
    nowMin     <= (bad && code == 4) ? 7'h46 : (bad && code == 5) ? 7'h55 : 7'h45;
    nowHour    <= (bad && code == 6) ? 6'h13 : 6'h12;
    nowWday    <= (bad && code == 7) ? 3'h4 : 3'h3;
    nowDay     <= (bad && code == 8) ? 6'h16 : 6'h15;
    nowMonth   <= (bad && code == 9) ? 5'h12 : 5'h11;
    @(posedge clock);
    halfTick <= 1'b0;
    @(negedge clock);
    if (expIrq)
      expPulse = ~expPulse;
    `CHK(alarmIrq, expIrq)
    `CHK(alarmPulse, expPulse)
  endtask : tick

  task automatic minute(input logic expApply, input logic [9:0] expPulses);
    @(posedge clock);
    minuteTick <= 1'b1;
    @(posedge clock);
    minuteTick <= 1'b0;
    @(negedge clock);
    `CHK(calApply, expApply)
    if (expApply)
      `CHK(calPulses, expPulses)
  endtask : minute

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, halfTick, secondEdge, minuteTick} = '0;
    {nowSec, nowMin, nowHour, nowWday, nowDay, nowMonth} = '0;
    clockSync = 1'b0;
    ce = 1'b1;
    rstn = 1'b0;
    expPulse = 1'b0;
    miscompares = 0;
    compares = 0;
    rows = '{'{`RAC_OFS_CAL, 32'h0000_20FD, 32'h0000_20FD, 1'b0},
             '{`RAC_OFS_WDHR, 32'hFFFF_FFFF, 32'h0000_073F, 1'b0},
             '{`RAC_OFS_MINSEC, 32'hFFFF_FFFF, 32'h0000_7F7F, 1'b0},
             '{8'h18, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1},
             '{8'h1C, 32'h0000_1234, 32'h0000_0000, 1'b1},
             '{`RAC_OFS_CFG, 32'h0000_245A, 32'h0000_245A, 1'b0}};
    repeat (20) @(posedge clock);
    rstn <= 1'b1;
    @(negedge clock);
    `CHK({alarmIrq, alarmPulse, calApply, timerOn}, 4'h0)
    for (int i = 0; i < 6; i++)
      rd(8'(4 * i), 32'h0000_0000);
    $display("test reset done");
    // register rows: write, then read back
    foreach (rows[i])
    begin
      apb(1'b1, rows[i].a, rows[i].w);
      `CHK(errv, rows[i].e)
      rd(rows[i].a, rows[i].r);
      `CHK(errv, rows[i].e)
    end
    $display("test register rows done");
    // weekday/hours write is dropped without write enable
    apb(1'b1, `RAC_OFS_CAL, 32'h0000_00FD);
    apb(1'b1, `RAC_OFS_WDHR, 32'h0000_0101);
    rd(`RAC_OFS_WDHR, 32'h0000_073F);
    apb(1'b1, `RAC_OFS_CAL, 32'h0000_20FD);
    $display("test write enable done");
    // window pointer steps down on high half access and stops at zero
    apb(1'b1, `RAC_OFS_CFG, 32'h0000_0100);
    rd(`RAC_OFS_WINLO, 32'h0000_003F);
    rd(`RAC_OFS_WINHI, 32'h0000_0007);
    rd(`RAC_OFS_CFG, 32'h0000_0000);
    rd(`RAC_OFS_WINHI, 32'h0000_007F);
    rd(`RAC_OFS_WINLO, 32'h0000_007F);
    // window writes land in the selected pair; the high half steps the pointer down
    apb(1'b1, `RAC_OFS_CFG, 32'h0000_0100);
    apb(1'b1, `RAC_OFS_WINLO, 32'h0000_0011);
    apb(1'b1, `RAC_OFS_WINHI, 32'h0000_0002);
    apb(1'b1, `RAC_OFS_WINLO, 32'h0000_0026);
    rd(`RAC_OFS_WDHR, 32'h0000_0211);
    rd(`RAC_OFS_MINSEC, 32'h0000_7F26);
    $display("test pointer done");
    // alarm values loaded while the alarm is off
    apb(1'b1, `RAC_OFS_WDHR, 32'h0000_0312);
    apb(1'b1, `RAC_OFS_MINSEC, 32'h0000_4527);
    for (int m = 0; m <= int'(RAC_YEAR); m++)
    begin
      apb(1'b1, `RAC_OFS_CFG, 32'h0000_8000 | (32'(m) << 10));
      if (m != 0)
        tick(m, 1'b1, 1'b0);
      tick(m, 1'b0, 1'b1);
      tick(m, 1'b0, 1'b0);
      rd(`RAC_OFS_CFG, 32'(m) << 10);
    end
    $display("test mask codes done");
    // enable off blocks a matching instant
    tick(0, 1'b0, 1'b0);
    // reserved mask codes never match; a low clock enable drops the tick
    apb(1'b1, `RAC_OFS_CFG, 32'h0000_A800);
    tick(0, 1'b0, 1'b0);
    apb(1'b1, `RAC_OFS_CFG, 32'h0000_8000);
    ce <= 1'b0;
    tick(0, 1'b0, 1'b0);
    @(posedge clock);
    ce <= 1'b1;
    tick(0, 1'b0, 1'b1);
    // two repeats: three alarms, then self-disable
    apb(1'b1, `RAC_OFS_CFG, 32'h0000_8002);
    for (int k = 0; k < 4; k++)
      tick(0, 1'b0, k < 3);
    rd(`RAC_OFS_CFG, 32'h0000_0000);
    // chime wraps the counter and keeps the alarm on
    apb(1'b1, `RAC_OFS_CFG, 32'h0000_C000);
    tick(0, 1'b0, 1'b1);
    rd(`RAC_OFS_CFG, 32'h0000_C0FF);
    // FF gives 255 alarms after the first
    apb(1'b1, `RAC_OFS_CFG, 32'h0000_80FF);
    repeat (256) tick(0, 1'b0, 1'b1);
    tick(0, 1'b0, 1'b0);
    rd(`RAC_OFS_CFG, 32'h0000_0000);
    $display("test repeat done");
    // calibration: loaded with timer off, applied once per minute
    foreach (calVal[i])
    begin
      apb(1'b1, `RAC_OFS_CAL, 32'h0000_2000 | 32'(calVal[i]));
      minute(1'b0, 10'h000);
      apb(1'b1, `RAC_OFS_CAL, 32'h0000_A000 | 32'(calVal[i]));
      @(negedge clock);
      `CHK(timerOn, 1'b1)
      minute(1'b1, calExp[i]);
    end
    @(posedge clock);
    clockSync <= 1'b1;
    rd(`RAC_OFS_CAL, 32'h0000_B07F);
    $display("test calibration done");
    end_of_test();
  end

endmodule : test_rtc_alarm_and_calibration
